// file: dv/tb_watchdog_timer_unit.sv
// Self-checking testbench for the watchdog timer unit.
// Assumes wtu_pkg is compiled first and one 125 MHz bus clock drives all.
`timescale 1ns/100ps
`default_nettype none

module tb_watchdog_timer_unit;
    import wtu_pkg::*;

    // ==================================================================
    // Signals and bench state
    // ==================================================================
    logic         clock_in;       // Bus clock, 8 ns
    logic         rst_n_in;       // Reset, active low
    wtu_ahb_req_t req;            // Address phase to the block
    logic [31:0]  hwdata_in;      // Write data phase
    logic [31:0]  hrdata_out;     // Read data phase
    logic         hreadyout_out;  // Ready from block
    logic         hresp_out;      // Response from block
    logic         fast_osc_in = 1'b0;    // Fast oscillator, 8 cycle period
    logic         slow_osc_in = 1'b0;    // Slow oscillator, 16 cycle period
    logic         ext_crystal_in = 1'b0; // Crystal, 24 cycle period
    logic         reset_prev = 1'b0;     // Reset output one cycle earlier
    logic         chip_reset_out; // Timeout reset pulse
    logic         irq_out;        // Timeout interrupt
    int           num_errors;     // Mismatches
    int           checks;         // Comparisons made
    int           osc_cnt = 0;     // Oscillator phase counter
    int           resets_seen = 0; // Chip reset pulses seen
    int           n;              // Measured wait in cycles
    int           per [3];        // Oscillator periods in cycles
    logic [1:0]   sel [3];        // Matching source codes
    logic [31:0]  rd;             // Read scratch

    // Good key in the upper half of each keyed write
    localparam logic [31:0] KEY = {WTU_WRITE_KEY, 16'h0000};

    // ==================================================================
    // Design under test
    // ==================================================================
    wtu_watchdog wtu_watchdog_i
    (
        .clock_in       (clock_in),
        .rst_n_in       (rst_n_in),
        .ahb_req_in     (req),
        .hwdata_in      (hwdata_in),
        .hrdata_out     (hrdata_out),
        .hreadyout_out  (hreadyout_out),
        .hresp_out      (hresp_out),
        .fast_osc_in    (fast_osc_in),
        .slow_osc_in    (slow_osc_in),
        .ext_crystal_in (ext_crystal_in),
        .chip_reset_out (chip_reset_out),
        .irq_out        (irq_out)
    );

    // ==================================================================
    // Clock and oscillators
    // ==================================================================
    // Free-running bus clock
    initial
    begin
        clock_in = 1'b0;
        forever #4 clock_in = ~clock_in;
    end

    // Three unequal rates, so a wrong source select shows in the timing
    always @(posedge clock_in)
    begin
        osc_cnt        <= osc_cnt + 1;
        fast_osc_in    <= (osc_cnt % 8) < 4;
        slow_osc_in    <= (osc_cnt % 16) < 8;
        ext_crystal_in <= (osc_cnt % 24) < 12;
    end

    // Reset pulses are counted; a pulse must last one cycle only
    always @(posedge clock_in)
    begin
        if (chip_reset_out === 1'b1)
        begin
            resets_seen++;
            check({31'h0, reset_prev}, 32'h0);
        end
        reset_prev <= chip_reset_out;
    end

    // ==================================================================
    // Shared tasks
    // ==================================================================
    // Compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("ERROR at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    // Zero-wait write: address phase, then data phase
    task automatic bus_write(input logic [3:0] off, input logic [31:0] data);
        @(posedge clock_in);
        req <= '{1'b1, {28'h0, off}, 2'h2, 1'b1, 3'h2, 1'b1};
        @(posedge clock_in);
        req <= '{1'b0, 32'h0, 2'h0, 1'b0, 3'h2, 1'b1};
        hwdata_in <= data;
        @(posedge clock_in);
    endtask

    // Read data is looked at inside its one data phase cycle
    task automatic read_check(input logic [3:0] off, input logic [31:0] exp);
        @(posedge clock_in);
        req <= '{1'b1, {28'h0, off}, 2'h2, 1'b0, 3'h2, 1'b1};
        @(posedge clock_in);
        req <= '{1'b0, 32'h0, 2'h0, 1'b0, 3'h2, 1'b1};
        #1;
        rd = hrdata_out;
        check(rd, exp);
        @(posedge clock_in);
    endtask

    // Bounded wait for the interrupt; cnt equals limit if none came
    task automatic wait_irq(input int limit, output int cnt);
        cnt = 0;
        while (irq_out !== 1'b1 && cnt < limit)
        begin
            @(posedge clock_in);
            #1;
            cnt++;
        end
    endtask

    // Verdict and end of run
    task automatic print_verdict();
        if (num_errors == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // ==================================================================
    // Watchdog on the bench itself: about 7k cycles are expected
    // ==================================================================
    initial
    begin
        repeat (50000) @(posedge clock_in);
        num_errors++;
        print_verdict();
    end

    // ==================================================================
    // Test sequence
    // ==================================================================
    initial
    begin
        rst_n_in   = 1'b0;
        req        = '{1'b0, 32'h0, 2'h0, 1'b0, 3'h2, 1'b1};
        hwdata_in  = 32'h0;
        num_errors = 0;
        checks     = 0;
        per = '{8, 16, 24};
        sel = '{WTU_SEL_FAST_OSC, WTU_SEL_SLOW_OSC, WTU_SEL_EXT_XTAL};
        repeat (20) @(posedge clock_in);
        rst_n_in <= 1'b1;
        repeat (3) @(posedge clock_in);

        // Reset values, write-only feed, unmapped offset, bus answers
        read_check(WTU_OFF_CONFIG, 32'h0);
        read_check(WTU_OFF_CLOCK_SOURCE, 32'h0);
        read_check(WTU_OFF_RELOAD, 32'hff);
        read_check(WTU_OFF_FEED, 32'h0);
        read_check(4'h2, 32'h0);
        check({hreadyout_out, hresp_out}, 32'h2);

        // Wrong key leaves registers alone; good key lands, key reads 0
        bus_write(WTU_OFF_CONFIG, 32'h12340003);
        read_check(WTU_OFF_CONFIG, 32'h0);
        bus_write(WTU_OFF_CLOCK_SOURCE, KEY | 32'(WTU_SEL_BUS_CLK));
        read_check(WTU_OFF_CLOCK_SOURCE, 32'h1);
        bus_write(WTU_OFF_RELOAD, KEY | 32'h1);
        read_check(WTU_OFF_RELOAD, 32'h1);

        // Interrupt mode on the bus clock: (1+1)*128 cycles to timeout
        bus_write(WTU_OFF_CONFIG, KEY | 32'h3);
        wait_irq(400, n);
        check(32'(n >= 252 && n <= 262), 32'h1);
        read_check(WTU_OFF_CONFIG, 32'h7);
        check(32'(resets_seen), 32'h0);
        // Mode off with flag still set drops the request
        bus_write(WTU_OFF_CONFIG, KEY | 32'h5);
        #1;
        check({31'h0, irq_out}, 32'h0);
        read_check(WTU_OFF_CONFIG, 32'h5);
        // Feed first, then clear the flag with a zero
        bus_write(WTU_OFF_FEED, KEY | 32'(WTU_FEED_VALUE));
        bus_write(WTU_OFF_CONFIG, KEY | 32'h1);
        read_check(WTU_OFF_CONFIG, 32'h1);

        // Reset mode: regular feeds keep it quiet
        repeat (3)
        begin
            repeat (150) @(posedge clock_in);
            bus_write(WTU_OFF_FEED, KEY | 32'(WTU_FEED_VALUE));
        end
        check(32'(resets_seen), 32'h0);
        // Wrong pattern, then right pattern with wrong key: no feed
        n = 0;
        fork
            begin
                repeat (100) @(posedge clock_in);
                bus_write(WTU_OFF_FEED, KEY | 32'h1234);
                repeat (60) @(posedge clock_in);
                bus_write(WTU_OFF_FEED, 32'h000055aa);
            end
            while (resets_seen == 0 && n < 400)
            begin
                @(posedge clock_in);
                #1;
                n++;
            end
        join
        check(32'(n >= 252 && n <= 262), 32'h1);
        check(32'(resets_seen), 32'h1);
        read_check(WTU_OFF_CONFIG, 32'h1);

        // Each oscillator source with reload 0: 128 source periods
        bus_write(WTU_OFF_CONFIG, KEY);
        bus_write(WTU_OFF_RELOAD, KEY);
        for (int i = 0; i < 3; i++)
        begin
            bus_write(WTU_OFF_CLOCK_SOURCE, KEY | 32'(sel[i]));
            read_check(WTU_OFF_CLOCK_SOURCE, 32'(sel[i]));
            bus_write(WTU_OFF_CONFIG, KEY | 32'h3);
            wait_irq(4000, n);
            check(32'(n >= 127 * per[i] - 8 && n <= 129 * per[i] + 8),
                  32'h1);
            bus_write(WTU_OFF_FEED, KEY | 32'(WTU_FEED_VALUE));
            bus_write(WTU_OFF_CONFIG, KEY);
        end
        read_check(WTU_OFF_CONFIG, 32'h0);
        print_verdict();
    end

endmodule

`default_nettype wire

// file: logic/wtu_pkg.sv
// Package for the watchdog timer unit: register map, fields, reset values.
// Assumes a 32-bit AHB-Lite style register port on a single system clock.
package wtu_pkg;

    // ==================================================================
    // Register byte offsets
    // ==================================================================
    localparam logic [3:0]  WTU_OFF_CONFIG       = 4'h0; // Config
    localparam logic [3:0]  WTU_OFF_CLOCK_SOURCE = 4'h4; // Clock source
    localparam logic [3:0]  WTU_OFF_RELOAD       = 4'h8; // Reload constant
    localparam logic [3:0]  WTU_OFF_FEED         = 4'hc; // Feed, write only

    // ==================================================================
    // Field positions
    // ==================================================================
    localparam int          WTU_KEY_LSB          = 16;   // Write key low bit
    localparam int          WTU_BIT_ENABLE       = 0;    // Enable bit
    localparam int          WTU_BIT_INT_MODE     = 1;    // Interrupt mode bit
    localparam int          WTU_BIT_FLAG         = 2;    // Timeout flag bit

    // ==================================================================
    // Key and feed values
    // ==================================================================
    localparam logic [15:0] WTU_WRITE_KEY        = 16'h5afa; // Write key
    localparam logic [15:0] WTU_FEED_VALUE       = 16'h55aa; // Feed pattern

    // ==================================================================
    // Reset values
    // ==================================================================
    localparam logic        WTU_RST_ENABLE       = 1'h0; // Disabled
    localparam logic        WTU_RST_INT_MODE     = 1'h0; // Reset mode
    localparam logic        WTU_RST_FLAG         = 1'h0; // No timeout
    localparam logic [1:0]  WTU_RST_CLK_SEL      = 2'h0; // Fast oscillator
    localparam logic [7:0]  WTU_RST_RELOAD       = 8'hff; // 256 ticks

    // ==================================================================
    // Counting clock source codes
    // ==================================================================
    localparam logic [1:0]  WTU_SEL_FAST_OSC     = 2'h0; // Internal fast
    localparam logic [1:0]  WTU_SEL_BUS_CLK      = 2'h1; // Bus clock
    localparam logic [1:0]  WTU_SEL_SLOW_OSC     = 2'h2; // Internal slow
    localparam logic [1:0]  WTU_SEL_EXT_XTAL     = 2'h3; // External crystal

    // ==================================================================
    // Prescaler
    // ==================================================================
    localparam int          WTU_PRESCALE         = 128;  // Fixed divider
    localparam logic [6:0]  WTU_PRESCALE_LAST    = 7'(WTU_PRESCALE - 1);

    // AHB transfer type bit that marks NONSEQ or SEQ
    localparam int          WTU_HTRANS_ACTIVE    = 1;

    // Address phase signals from the AHB master
    typedef struct packed {
        logic        hsel;   // Slave select
        logic [31:0] haddr;  // Byte address
        logic [1:0]  htrans; // Transfer type
        logic        hwrite; // Write when high
        logic [2:0]  hsize;  // Transfer size
        logic        hready; // Previous transfer done
    } wtu_ahb_req_t;

endpackage

// file: logic/wtu_watchdog.sv
// Watchdog timer unit: fixed prescaler, 8-bit down-counter, keyed registers.
// Assumes the oscillator sources are slow against clock_in and asynchronous;
// the chip reset controller acts on chip_reset_out.
`timescale 1ns/100ps
`default_nettype none

module wtu_watchdog
(
    input  wire logic                  clock_in,        // 125 MHz bus clock
    input  wire logic                  rst_n_in,        // Async reset, low
    input  wire wtu_pkg::wtu_ahb_req_t ahb_req_in,      // Address phase
    input  wire logic [31:0]           hwdata_in,       // Write data
    output logic [31:0]                hrdata_out,      // Read data
    output logic                       hreadyout_out,   // Never stalls
    output logic                       hresp_out,       // Always OKAY
    input  wire logic                  fast_osc_in,     // Internal fast osc
    input  wire logic                  slow_osc_in,     // Internal slow osc
    input  wire logic                  ext_crystal_in,  // External crystal
    output logic                       chip_reset_out,  // Timeout reset
    output logic                       irq_out          // Timeout interrupt
);
    import wtu_pkg::*;

    // ==================================================================
    // Reset release
    // ==================================================================
    logic       rst_meta_q;    // First release stage
    logic       rst_sync_n_q;  // Released reset used everywhere

    // Assert at once, release through two flops
    always_ff @(posedge clock_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            rst_meta_q   <= 1'b0;
            rst_sync_n_q <= 1'b0;
        end
        else
        begin
            rst_meta_q   <= 1'b1;
            rst_sync_n_q <= rst_meta_q;
        end
    end

    // ==================================================================
    // Helper functions
    // ==================================================================
    // Matches a byte offset within the block
    function automatic logic wtu_hit(input logic [3:0] addr,
                                     input logic [3:0] off);
        wtu_hit = (addr == off);
    endfunction

    // ==================================================================
    // AHB-Lite slave
    // ==================================================================
    logic       wr_pend_q;   // Write data phase pending
    logic       rd_pend_q;   // Read data phase pending
    logic [3:0] addr_q;      // Captured low address
    wire        req_valid;   // Transfer accepted this cycle

    assign req_valid = ahb_req_in.hsel & ahb_req_in.hready
                     & ahb_req_in.htrans[WTU_HTRANS_ACTIVE];

    // Capture address phase for the following data phase
    always_ff @(posedge clock_in or negedge rst_sync_n_q)
    begin
        if (!rst_sync_n_q)
        begin
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            addr_q    <= 4'h0;
        end
        else
        begin
            wr_pend_q <= req_valid & ahb_req_in.hwrite;
            rd_pend_q <= req_valid & ~ahb_req_in.hwrite;
            if (req_valid)
            begin
                addr_q <= ahb_req_in.haddr[3:0];
            end
        end
    end

    // Zero wait states, never an error response
    assign hreadyout_out = 1'b1;
    assign hresp_out     = 1'b0;

    // Write strobes, all gated by the key in the upper half
    wire        key_ok;      // Key matches
    wire        wr_ok;       // Accepted write this cycle
    wire        wr_config;   // Config write
    wire        wr_clk_src;  // Clock source write
    wire        wr_reload;   // Reload constant write
    wire        feed_hit;    // Valid feed

    assign key_ok     = (hwdata_in[31:WTU_KEY_LSB] == WTU_WRITE_KEY);
    assign wr_ok      = wr_pend_q & key_ok;
    assign wr_config  = wr_ok & wtu_hit(addr_q, WTU_OFF_CONFIG);
    assign wr_clk_src = wr_ok & wtu_hit(addr_q, WTU_OFF_CLOCK_SOURCE);
    assign wr_reload  = wr_ok & wtu_hit(addr_q, WTU_OFF_RELOAD);
    assign feed_hit   = wr_ok & wtu_hit(addr_q, WTU_OFF_FEED)
                      & (hwdata_in[15:0] == WTU_FEED_VALUE);

    // ==================================================================
    // Software registers
    // ==================================================================
    logic       enable_q;    // Watchdog running
    logic       int_mode_q;  // 1 interrupt, 0 chip reset
    logic [1:0] clk_sel_q;   // Counting clock source
    logic [7:0] reload_q;    // Reload constant
    logic       flag_q;      // Timeout flag
    logic       flag_d;      // Next timeout flag
    logic       timeout;     // Underflow this cycle
    logic       reset_q;     // Chip reset pulse
    wire        en_rise;     // Enable written from zero to one

    assign en_rise = wr_config & hwdata_in[WTU_BIT_ENABLE] & ~enable_q;

    // Fields, flag and one-cycle reset pulse; a bad key changes no field
    always_ff @(posedge clock_in or negedge rst_sync_n_q)
    begin
        if (!rst_sync_n_q)
        begin
            enable_q   <= WTU_RST_ENABLE;
            int_mode_q <= WTU_RST_INT_MODE;
            clk_sel_q  <= WTU_RST_CLK_SEL;
            reload_q   <= WTU_RST_RELOAD;
            flag_q     <= WTU_RST_FLAG;
            reset_q    <= 1'b0;
        end
        else
        begin
            flag_q     <= flag_d;
            reset_q    <= timeout & ~int_mode_q;
            if (wr_config)
            begin
                enable_q   <= hwdata_in[WTU_BIT_ENABLE];
                int_mode_q <= hwdata_in[WTU_BIT_INT_MODE];
            end
            if (wr_clk_src)
            begin
                clk_sel_q <= hwdata_in[1:0];
            end
            if (wr_reload)
            begin
                reload_q <= hwdata_in[7:0];
            end
        end
    end

    // Flag: a timeout in interrupt mode beats a same-cycle clear
    always_comb
    begin
        flag_d = flag_q;
        if (timeout && int_mode_q)
        begin
            flag_d = 1'b1;
        end
        else if (timeout)
        begin
            flag_d = 1'b0;
        end
        else if (wr_config && !hwdata_in[WTU_BIT_FLAG])
        begin
            flag_d = 1'b0;
        end
    end

    // Read mux; key half and feed register always read as zero
    wire [31:0] rd_word;     // Selected read word
    assign rd_word =
        wtu_hit(addr_q, WTU_OFF_CONFIG)       ?
            {29'h0, flag_q, int_mode_q, enable_q} :
        wtu_hit(addr_q, WTU_OFF_CLOCK_SOURCE) ? {30'h0, clk_sel_q} :
        wtu_hit(addr_q, WTU_OFF_RELOAD)       ? {24'h0, reload_q}  :
        32'h0;

    // Only drive data in a read data phase; mux of flops
    assign hrdata_out = rd_pend_q ? rd_word : 32'h0;

    // ==================================================================
    // Counting clock sources
    // ==================================================================
    // Oscillators are asynchronous: two flops, then edge detect on the
    // second stage. Sources faster than half of clock_in lose edges.
    logic [2:0] osc_meta_q;  // First sync stage
    logic [2:0] osc_sync_q;  // Second sync stage
    logic [2:0] osc_prev_q;  // Edge detect history
    wire  [2:0] osc_raw;     // Raw source pins
    wire  [2:0] osc_rise;    // Rising edges

    assign osc_raw = {ext_crystal_in, slow_osc_in, fast_osc_in};

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++)
        begin : g_osc
            // Synchroniser and edge history for one source
            always_ff @(posedge clock_in or negedge rst_sync_n_q)
            begin
                if (!rst_sync_n_q)
                begin
                    osc_meta_q[gi] <= 1'b0;
                    osc_sync_q[gi] <= 1'b0;
                    osc_prev_q[gi] <= 1'b0;
                end
                else
                begin
                    osc_meta_q[gi] <= osc_raw[gi];
                    osc_sync_q[gi] <= osc_meta_q[gi];
                    osc_prev_q[gi] <= osc_sync_q[gi];
                end
            end
            assign osc_rise[gi] = osc_sync_q[gi] & ~osc_prev_q[gi];
        end
    endgenerate

    // One enable pulse per counting clock period
    wire        src_tick;    // Selected source edge
    assign src_tick =
        (clk_sel_q == WTU_SEL_FAST_OSC) ? osc_rise[0] :
        (clk_sel_q == WTU_SEL_BUS_CLK)  ? 1'b1        :
        (clk_sel_q == WTU_SEL_SLOW_OSC) ? osc_rise[1] :
        osc_rise[2];

    // ==================================================================
    // Prescaler and down-counter
    // ==================================================================
    logic [6:0] pre_q;       // Prescaler count
    logic [7:0] count_q;     // Watchdog counter
    wire        reload_evt;  // Load counter from constant
    wire        pre_tick;    // One per 128 source ticks

    assign reload_evt = en_rise | feed_hit;
    assign pre_tick   = enable_q & src_tick
                      & (pre_q == WTU_PRESCALE_LAST);
    assign timeout    = ~reload_evt & pre_tick
                      & (count_q == 8'h00);

    // Prescaler restarts on every load so intervals are exact
    always_ff @(posedge clock_in or negedge rst_sync_n_q)
    begin
        if (!rst_sync_n_q)
        begin
            pre_q <= 7'h00;
        end
        else if (reload_evt)
        begin
            pre_q <= 7'h00;
        end
        else if (enable_q && src_tick)
        begin
            pre_q <= pre_q + 7'h01;
        end
    end

    // Counter: loaded value N gives N+1 ticks until underflow
    always_ff @(posedge clock_in or negedge rst_sync_n_q)
    begin
        if (!rst_sync_n_q)
        begin
            count_q <= WTU_RST_RELOAD;
        end
        else if (reload_evt || timeout)
        begin
            count_q <= reload_q;
        end
        else if (pre_tick)
        begin
            count_q <= count_q - 8'h01;
        end
    end

    assign chip_reset_out = reset_q;
    assign irq_out        = flag_q & int_mode_q;

    // ==================================================================
    // Checks
    // ==================================================================
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rst_sync_n_q);

    logic [7:0] tick_gap_q;  // Source ticks since last prescaled tick
    // Counts source ticks between prescaled ticks
    always_ff @(posedge clock_in or negedge rst_sync_n_q)
    begin
        if (!rst_sync_n_q)
        begin
            tick_gap_q <= 8'h00;
        end
        else if (reload_evt || pre_tick)
        begin
            tick_gap_q <= 8'h00;
        end
        else if (enable_q && src_tick)
        begin
            tick_gap_q <= tick_gap_q + 8'h01;
        end
    end

    a_prescale_gap:
    assert property (pre_tick |-> tick_gap_q == 8'h7f)
        else $error("prescaled tick not after 128 source ticks");
    a_count_step:
    assert property (pre_tick && !reload_evt && count_q != 8'h00
                     |=> count_q == $past(count_q) - 8'h01)
        else $error("counter did not step down by one");
    a_enable_load:
    assert property (en_rise |=> enable_q && count_q == $past(reload_q)
                     && pre_q == 7'h00)
        else $error("enable did not load the reload constant");
    a_feed_reload:
    assert property (feed_hit |=> count_q == $past(reload_q) && !reset_q)
        else $error("feed did not reload the counter");
    a_bad_key_kept:
    assert property (wr_pend_q && !key_ok |=>
                     $stable(enable_q) && $stable(clk_sel_q)
                     && $stable(reload_q) && $stable(int_mode_q))
        else $error("write with bad key changed a register");
    a_key_reads_zero:
    assert property (rd_pend_q |-> hrdata_out[31:16] == 16'h0000
                     && (addr_q != WTU_OFF_FEED || hrdata_out == 32'h0))
        else $error("key or feed field read back nonzero");
    a_reset_mode:
    assert property (timeout && !int_mode_q |=> chip_reset_out && !flag_q
                     ##1 !chip_reset_out)
        else $error("reset mode timeout did not pulse reset");
    a_int_mode:
    assert property (timeout && int_mode_q |=> flag_q && irq_out
                     && !chip_reset_out)
        else $error("interrupt mode timeout did not raise flag");
    a_irq_gate:
    assert property ($rose(irq_out) |-> $past(timeout) || $rose(int_mode_q))
        else $error("interrupt rose without timeout or mode");
    a_flag_clear:
    assert property (wr_config && !hwdata_in[WTU_BIT_FLAG] && !timeout
                     |=> !flag_q)
        else $error("flag not cleared by writing zero");
    a_idle_when_off:
    assert property (!enable_q && !reload_evt |=> $stable(count_q)
                     && !chip_reset_out)
        else $error("counter moved while disabled");

endmodule

`default_nettype wire
